//--- src/uilms_defs.svh
// Constants of the serial-port interrupt level, mask and status block.
// Assumes it is included by bare name from the package and the top module.
`ifndef UILMS_DEFS_SVH
`define UILMS_DEFS_SVH

// ------------------------------------------------------------
// Register byte offsets on the AXI4-Lite bus
// ------------------------------------------------------------
`define UILMS_ADDR_W         8
`define UILMS_OFF_THRESHOLD  8'h00
`define UILMS_OFF_MASK       8'h04
`define UILMS_OFF_RAW        8'h08
`define UILMS_OFF_MASKED     8'h0C
`define UILMS_OFF_CLEAR      8'h10

// ------------------------------------------------------------
// Field positions and widths
// ------------------------------------------------------------
`define UILMS_SRC_W          11
`define UILMS_THR_W          6
`define UILMS_RX_THR_LSB     3
`define UILMS_TX_THR_LSB     0
`define UILMS_BIT_TX         5
`define UILMS_BIT_RX         4
`define UILMS_MODEM_MSB      3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define UILMS_THR_RESET      6'h12
`define UILMS_MASK_RESET     11'h000
`define UILMS_RAW_RESET      11'h000
`define UILMS_PIN_IDLE       4'hF

// ------------------------------------------------------------
// FIFO geometry and bus answers
// ------------------------------------------------------------
`define UILMS_FIFO_DEPTH     16
`define UILMS_LEVEL_W        5
`define UILMS_RESP_OKAY      2'h0
`define UILMS_RESP_SLVERR    2'h2

`endif

//--- src/uilms_pkg.sv
// Types shared by the interrupt level, mask and status block and its users.
// Assumes uilms_defs.svh is on the include path.
`include "uilms_defs.svh"

package uilms_pkg;

    // ------------------------------------------------------------
    // AXI4-Lite master-to-slave signals
    // ------------------------------------------------------------
    typedef struct packed {
        logic                       awvalid;
        logic [`UILMS_ADDR_W-1:0]   awaddr;
        logic                       wvalid;
        logic [31:0]                wdata;
        logic [3:0]                 wstrb;
        logic                       bready;
        logic                       arvalid;
        logic [`UILMS_ADDR_W-1:0]   araddr;
        logic                       rready;
    } uilms_axi_req_t;

    // ------------------------------------------------------------
    // AXI4-Lite slave-to-master signals
    // ------------------------------------------------------------
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } uilms_axi_rsp_t;

    // ------------------------------------------------------------
    // Error and timeout event pulses from the serial engine
    // ------------------------------------------------------------
    typedef struct packed {
        logic overrun;
        logic breakSeen;
        logic parity;
        logic framing;
        logic rxTimeout;
    } uilms_evt_t;

    // ------------------------------------------------------------
    // Per-source masked interrupt lines, in register bit order
    // ------------------------------------------------------------
    typedef struct packed {
        logic overrunIrq;
        logic breakIrq;
        logic parityIrq;
        logic framingIrq;
        logic rxTimeoutIrq;
        logic txFifoIrq;
        logic rxFifoIrq;
        logic setReadyChangeIrq;
        logic carrierChangeIrq;
        logic clearToSendChangeIrq;
        logic ringChangeIrq;
    } uilms_src_t;

endpackage : uilms_pkg

//--- src/uilms_top.sv
// Interrupt level select, mask and raw/masked status of a serial port.
// Assumes FIFO fill levels and event pulses come from logic on mclk, while the
// four modem-status inputs are asynchronous pins.
`timescale 1ns/1ps
`include "uilms_defs.svh"

module uilms_top (
    // Clock and reset.
    input  wire logic                      mclk,
    input  wire logic                      resetn,
    // AXI4-Lite register port.
    input  wire uilms_pkg::uilms_axi_req_t axiReq,
    output      uilms_pkg::uilms_axi_rsp_t axiRsp,
    // FIFO fill levels, in entries.
    input  wire logic [`UILMS_LEVEL_W-1:0] txFillLevel,
    input  wire logic [`UILMS_LEVEL_W-1:0] rxFillLevel,
    // Error and timeout event pulses.
    input  wire uilms_pkg::uilms_evt_t     evtPulse,
    // Modem-status pins, active low.
    input  wire logic                      setReadyInN,
    input  wire logic                      carrierInN,
    input  wire logic                      clearToSendInN,
    input  wire logic                      ringInN,
    // Interrupt outputs.
    output      uilms_pkg::uilms_src_t     srcIrq,
    output      logic                      uartIrq
);
    import uilms_pkg::*;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Entry count for a threshold code; reserved codes behave as half full.
    function automatic logic [`UILMS_LEVEL_W-1:0] thrLevel(input logic [2:0] code);
        int eighths;
        case (code)
            3'h0:    eighths = 1;
            3'h1:    eighths = 2;
            3'h2:    eighths = 4;
            3'h3:    eighths = 6;
            3'h4:    eighths = 7;
            default: eighths = 4;
        endcase
        thrLevel = `UILMS_LEVEL_W'((`UILMS_FIFO_DEPTH * eighths) / 8);
    endfunction

    // Bit mask of the low 16 bits that the byte strobes allow to change.
    function automatic logic [15:0] laneMask(input logic [3:0] strb);
        laneMask = {{8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rstMetaQ;
    logic rstnSync;

    // Assertion is immediate, release is two edges late to stay clear of recovery hazards.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rstMetaQ <= 1'b0;
            rstnSync <= 1'b0;
        end else begin
            rstMetaQ <= 1'b1;
            rstnSync <= rstMetaQ;
        end
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [`UILMS_THR_W-1:0]   thrQ;
    logic [`UILMS_THR_W-1:0]   thrD;
    logic [`UILMS_SRC_W-1:0]   maskQ;
    logic [`UILMS_SRC_W-1:0]   maskD;
    logic [`UILMS_SRC_W-1:0]   rawQ;
    logic [`UILMS_SRC_W-1:0]   rawD;
    logic [`UILMS_LEVEL_W-1:0] txPrevQ;
    logic [`UILMS_LEVEL_W-1:0] rxPrevQ;
    logic [3:0]                pinMetaQ;
    logic [3:0]                pinSyncQ;
    logic [3:0]                pinPrevQ;
    uilms_src_t                srcIrqQ;
    logic                      irqQ;

    // ------------------------------------------------------------
    // AXI4-Lite slave state
    // ------------------------------------------------------------
    logic                      awreadyQ;
    logic                      wreadyQ;
    logic                      bvalidQ;
    logic [1:0]                brespQ;
    logic                      arreadyQ;
    logic                      rvalidQ;
    logic [31:0]               rdataQ;
    logic [1:0]                rrespQ;
    logic [`UILMS_ADDR_W-1:0]  awAddrQ;
    logic [31:0]               wDataQ;
    logic [3:0]                wStrbQ;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire awHs    = axiReq.awvalid && awreadyQ;
    wire wHs     = axiReq.wvalid && wreadyQ;
    wire bHs     = bvalidQ && axiReq.bready;
    wire arHs    = axiReq.arvalid && arreadyQ;
    wire rHs     = rvalidQ && axiReq.rready;
    // Address and data both held and no response pending: the write takes effect now.
    wire wrFire  = !awreadyQ && !wreadyQ && !bvalidQ;
    wire wrThr   = wrFire && (awAddrQ == `UILMS_OFF_THRESHOLD);
    wire wrMask  = wrFire && (awAddrQ == `UILMS_OFF_MASK);
    wire wrClear = wrFire && (awAddrQ == `UILMS_OFF_CLEAR);
    // Raw and masked status accept writes as harmless no-ops, so they still answer OKAY.
    wire wrKnown = (awAddrQ == `UILMS_OFF_THRESHOLD) || (awAddrQ == `UILMS_OFF_MASK) ||
                   (awAddrQ == `UILMS_OFF_RAW) || (awAddrQ == `UILMS_OFF_MASKED) ||
                   (awAddrQ == `UILMS_OFF_CLEAR);
    wire [15:0] wrLanes = laneMask(wStrbQ);

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    logic [31:0] rdMux;
    logic        rdKnown;
    // Reserved bits are zero by construction; the clear register reads as zero.
    assign rdKnown = (axiReq.araddr == `UILMS_OFF_THRESHOLD) || (axiReq.araddr == `UILMS_OFF_MASK) ||
                     (axiReq.araddr == `UILMS_OFF_RAW) || (axiReq.araddr == `UILMS_OFF_MASKED) ||
                     (axiReq.araddr == `UILMS_OFF_CLEAR);
    assign rdMux   = (axiReq.araddr == `UILMS_OFF_THRESHOLD) ? {26'h000_0000, thrQ} :
                     (axiReq.araddr == `UILMS_OFF_MASK)      ? {21'h00_0000, maskQ} :
                     (axiReq.araddr == `UILMS_OFF_RAW)       ? {21'h00_0000, rawQ} :
                     (axiReq.araddr == `UILMS_OFF_MASKED)    ? {21'h00_0000, rawQ & maskQ} :
                     32'h0000_0000;

    // ------------------------------------------------------------
    // Threshold crossing detection
    // ------------------------------------------------------------
    wire [2:0] rxCode = thrQ[`UILMS_RX_THR_LSB +: 3];
    wire [2:0] txCode = thrQ[`UILMS_TX_THR_LSB +: 3];
    wire [`UILMS_LEVEL_W-1:0] rxTrip = thrLevel(rxCode);
    wire [`UILMS_LEVEL_W-1:0] txTrip = thrLevel(txCode);
    // Only the step across the trip point counts, so a FIFO parked beyond it fires once.
    wire rxCross = (rxPrevQ < rxTrip) && (rxFillLevel >= rxTrip);
    wire txCross = (txPrevQ > txTrip) && (txFillLevel <= txTrip);

    // ------------------------------------------------------------
    // Status set, clear and next values
    // ------------------------------------------------------------
    wire [3:0] modemChange = pinSyncQ ^ pinPrevQ;
    wire [`UILMS_SRC_W-1:0] setVec = {evtPulse.overrun, evtPulse.breakSeen, evtPulse.parity,
                                      evtPulse.framing, evtPulse.rxTimeout, txCross, rxCross,
                                      modemChange};
    wire [`UILMS_SRC_W-1:0] clrVec = wrClear ? (wDataQ[`UILMS_SRC_W-1:0] & wrLanes[`UILMS_SRC_W-1:0])
                                             : `UILMS_SRC_W'h000;
    // Set wins over clear so an event in the clearing cycle is not lost; raw writes are ignored.
    assign rawD  = (rawQ & ~clrVec) | setVec;
    assign maskD = wrMask ? ((maskQ & ~wrLanes[`UILMS_SRC_W-1:0]) |
                             (wDataQ[`UILMS_SRC_W-1:0] & wrLanes[`UILMS_SRC_W-1:0])) : maskQ;
    assign thrD  = wrThr ? ((thrQ & ~wrLanes[`UILMS_THR_W-1:0]) |
                            (wDataQ[`UILMS_THR_W-1:0] & wrLanes[`UILMS_THR_W-1:0])) : thrQ;

    // ------------------------------------------------------------
    // Control and status registers
    // ------------------------------------------------------------

    // Modem bits are cleared too, which the undefined reset state permits.
    always_ff @(posedge mclk or negedge rstnSync) begin
        if (!rstnSync) begin
            thrQ    <= `UILMS_THR_RESET;
            maskQ   <= `UILMS_MASK_RESET;
            rawQ    <= `UILMS_RAW_RESET;
            srcIrqQ <= '0;
            irqQ    <= 1'b0;
        end else begin
            thrQ    <= thrD;
            maskQ   <= maskD;
            rawQ    <= rawD;
            srcIrqQ <= uilms_src_t'(rawD & maskD);
            irqQ    <= |(rawD & maskD);
        end
    end

    // Previous fill levels; reset to empty for receive and full for transmit, so a level already past its trip point at start-up counts as a crossing.
    always_ff @(posedge mclk or negedge rstnSync) begin
        if (!rstnSync) begin
            txPrevQ <= `UILMS_LEVEL_W'(`UILMS_FIFO_DEPTH);
            rxPrevQ <= `UILMS_LEVEL_W'(0);
        end else begin
            txPrevQ <= txFillLevel;
            rxPrevQ <= rxFillLevel;
        end
    end

    // Modem pins: two-stage synchroniser, then a third stage for change detection.
    // All stages start at the idle high level, so leaving reset is not mistaken for a pin change.
    always_ff @(posedge mclk or negedge rstnSync) begin
        if (!rstnSync) begin
            pinMetaQ <= `UILMS_PIN_IDLE;
            pinSyncQ <= `UILMS_PIN_IDLE;
            pinPrevQ <= `UILMS_PIN_IDLE;
        end else begin
            pinMetaQ <= {setReadyInN, carrierInN, clearToSendInN, ringInN};
            pinSyncQ <= pinMetaQ;
            pinPrevQ <= pinSyncQ;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------

    // Ready drops after each capture and returns only when the response is accepted, one write at a time.
    always_ff @(posedge mclk or negedge rstnSync) begin
        if (!rstnSync) begin
            awreadyQ <= 1'b1;
            wreadyQ  <= 1'b1;
            bvalidQ  <= 1'b0;
            brespQ   <= `UILMS_RESP_OKAY;
            awAddrQ  <= '0;
            wDataQ   <= 32'h0000_0000;
            wStrbQ   <= 4'h0;
        end else begin
            if (awHs) begin
                awreadyQ <= 1'b0;
                awAddrQ  <= axiReq.awaddr;
            end
            if (wHs) begin
                wreadyQ <= 1'b0;
                wDataQ  <= axiReq.wdata;
                wStrbQ  <= axiReq.wstrb;
            end
            if (wrFire) begin
                bvalidQ <= 1'b1;
                brespQ  <= wrKnown ? `UILMS_RESP_OKAY : `UILMS_RESP_SLVERR;
            end else if (bHs) begin
                bvalidQ  <= 1'b0;
                awreadyQ <= 1'b1;
                wreadyQ  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------

    // Data is captured at the address handshake, so it shows the state of that edge.
    always_ff @(posedge mclk or negedge rstnSync) begin
        if (!rstnSync) begin
            arreadyQ <= 1'b1;
            rvalidQ  <= 1'b0;
            rdataQ   <= 32'h0000_0000;
            rrespQ   <= `UILMS_RESP_OKAY;
        end else if (arHs) begin
            arreadyQ <= 1'b0;
            rvalidQ  <= 1'b1;
            rdataQ   <= rdMux;
            rrespQ   <= rdKnown ? `UILMS_RESP_OKAY : `UILMS_RESP_SLVERR;
        end else if (rHs) begin
            arreadyQ <= 1'b1;
            rvalidQ  <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign axiRsp = '{awready: awreadyQ, wready: wreadyQ, bvalid: bvalidQ, bresp: brespQ,
                      arready: arreadyQ, rvalid: rvalidQ, rdata: rdataQ, rresp: rrespQ};
    assign srcIrq  = srcIrqQ;
    assign uartIrq = irqQ;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstnSync);

    sequence sRawRead;
        arHs && (axiReq.araddr == `UILMS_OFF_RAW);
    endsequence

    sequence sThrRead;
        arHs && (axiReq.araddr == `UILMS_OFF_THRESHOLD);
    endsequence

    sequence sMaskFullWrite;
        wrMask && (wStrbQ[1:0] == 2'h3);
    endsequence

    AST_RX_ONLY_ON_CROSS: assert property ($rose(rawQ[`UILMS_BIT_RX]) |-> $past(rxCross))
        else $error("Receive status rose without a threshold crossing.");

    AST_THR_RESET: assert property ($rose(rstnSync) |-> thrQ == `UILMS_THR_RESET)
        else $error("Threshold fields not at half full after reset.");

    AST_RX_CROSS_SETS: assert property (rxCross |=>
        rawQ[`UILMS_BIT_RX] && srcIrq.rxFifoIrq == maskQ[`UILMS_BIT_RX])
        else $error("Receive crossing did not set receive status.");

    AST_TX_CROSS_SETS: assert property (txCross |=> rawQ[`UILMS_BIT_TX])
        else $error("Transmit crossing did not set transmit status.");

    AST_THR_UPPER_ZERO: assert property (sThrRead |=> axiRsp.rvalid && axiRsp.rdata[31:6] == 26'h000_0000)
        else $error("Reserved threshold bits read nonzero.");

    AST_MASK_WRITE: assert property (sMaskFullWrite |=> maskQ == $past(wDataQ[10:0]))
        else $error("Mask register did not take the written value.");

    AST_MASK_RESET: assert property ($rose(rstnSync) |-> maskQ == `UILMS_MASK_RESET)
        else $error("Mask not zero after reset.");

    AST_RAW_WRITE_IGNORED: assert property (
        wrFire && awAddrQ == `UILMS_OFF_RAW && setVec == '0 |=> $stable(rawQ))
        else $error("Write to raw status changed interrupt state.");

    AST_RAW_READ: assert property (sRawRead |=> axiRsp.rdata[10:0] == $past(rawQ))
        else $error("Raw status read does not match the unmasked state.");

    AST_RAW_RESET: assert property ($rose(rstnSync) |-> rawQ[10:4] == 7'h00)
        else $error("Raw status bits 10 to 4 not cleared by reset.");

    AST_MASKED_OUT: assert property (
        ##1 srcIrq == uilms_src_t'(rawQ & maskQ) && uartIrq == |(rawQ & maskQ))
        else $error("Masked outputs disagree with raw status and mask.");

    AST_CLEAR: assert property (wrClear |=> (rawQ & $past(clrVec & ~setVec)) == 11'h000)
        else $error("Clear register write left a pending interrupt set.");

endmodule // uilms_top

//--- dv/uilms_top_tb.sv
// Self-checking bench of the serial-port interrupt level, mask and status block.
// Assumes uilms_pkg and uilms_defs.svh are compiled first and on the include path.
`timescale 1ns/1ps
`include "uilms_defs.svh"

module uilms_top_tb;
    import uilms_pkg::*;

    // ------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------
    localparam logic [4:0] TRIP [5] = '{5'h02, 5'h04, 5'h08, 5'h0C, 5'h0E};
    logic           mclk           = 1'b0;
    logic           resetn         = 1'b0;
    uilms_axi_req_t axiReq         = '0;
    uilms_axi_rsp_t axiRsp;
    logic [4:0]     txLvl          = 5'h10;
    logic [4:0]     rxLvl          = 5'h00;
    uilms_evt_t     evtPulse       = '0;
    logic           setReadyInN    = 1'b1;
    logic           carrierInN     = 1'b1;
    logic           clearToSendInN = 1'b1;
    logic           ringInN        = 1'b1;
    uilms_src_t     srcIrq;
    logic           uartIrq;
    logic [31:0]    rdVal;
    logic [1:0]     lastResp;
    int             n_fail         = 0;
    int             cmp_count      = 0;

    // Free-running 40 MHz register clock.
    always #12.5 mclk = ~mclk;

    uilms_top dut (
        .mclk           (mclk),
        .resetn         (resetn),
        .axiReq         (axiReq),
        .axiRsp         (axiRsp),
        .txFillLevel    (txLvl),
        .rxFillLevel    (rxLvl),
        .evtPulse       (evtPulse),
        .setReadyInN    (setReadyInN),
        .carrierInN     (carrierInN),
        .clearToSendInN (clearToSendInN),
        .ringInN        (ringInN),
        .srcIrq         (srcIrq),
        .uartIrq        (uartIrq)
    );

    // ------------------------------------------------------------
    // Bus and checking tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask

    // Address and data go out together; each is dropped once its own ready is seen.
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        logic awDone;
        logic wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge mclk);
        axiReq.awaddr  <= a;
        axiReq.wdata   <= d;
        axiReq.wstrb   <= 4'hF;
        axiReq.awvalid <= 1'b1;
        axiReq.wvalid  <= 1'b1;
        axiReq.bready  <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge mclk);
            if (!awDone && axiRsp.awready === 1'b1) begin
                awDone = 1'b1;
                axiReq.awvalid <= 1'b0;
            end
            if (!wDone && axiRsp.wready === 1'b1) begin
                wDone = 1'b1;
                axiReq.wvalid <= 1'b0;
            end
        end
        do @(posedge mclk); while (axiRsp.bvalid !== 1'b1);
        lastResp = axiRsp.bresp;
        axiReq.bready <= 1'b0;
    endtask

    task automatic axiRead(input logic [7:0] a);
        @(posedge mclk);
        axiReq.araddr  <= a;
        axiReq.arvalid <= 1'b1;
        axiReq.rready  <= 1'b1;
        do @(posedge mclk); while (axiRsp.arready !== 1'b1);
        axiReq.arvalid <= 1'b0;
        do @(posedge mclk); while (axiRsp.rvalid !== 1'b1);
        rdVal = axiRsp.rdata;
        lastResp = axiRsp.rresp;
        axiReq.rready <= 1'b0;
    endtask

    task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        axiRead(a);
        chk(nm, exp, rdVal);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    // Watchdog: the sequence needs a few hundred cycles, so this is ample.
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        complete_run();
    end

    // Main sequence; expectations come from the register layout alone.
    initial begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        repeat (5) @(posedge mclk);
        rdChk("thrReset", `UILMS_OFF_THRESHOLD, 32'h0000_0012);
        rdChk("maskReset", `UILMS_OFF_MASK, 32'h0000_0000);
        axiRead(`UILMS_OFF_RAW);
        chk("rawReset", 32'h0000_0000, rdVal & 32'hFFFF_FFF0);
        axiWrite(`UILMS_OFF_MASK, 32'h0000_07FF);
        rdChk("maskAll", `UILMS_OFF_MASK, 32'h0000_07FF);
        axiWrite(`UILMS_OFF_MASK, 32'h0000_0000);
        rdChk("maskNone", `UILMS_OFF_MASK, 32'h0000_0000);
        axiWrite(`UILMS_OFF_CLEAR, 32'h0000_07FF);
        // Each event lands on its own bit, and the set bits accumulate.
        for (int i = 0; i < 5; i++) begin
            @(posedge mclk);
            evtPulse <= uilms_evt_t'(5'h01 << i);
            @(posedge mclk);
            evtPulse <= '0;
            rdChk("rawEvt", `UILMS_OFF_RAW, ((32'h0000_0002 << i) - 1) << 6);
        end
        chk("irqOffMasked", 32'h0, uartIrq);
        axiWrite(`UILMS_OFF_RAW, 32'h0000_0000);
        chk("rawWrResp", `UILMS_RESP_OKAY, lastResp);
        axiWrite(`UILMS_OFF_MASKED, 32'h0000_0000);
        rdChk("rawNoWr", `UILMS_OFF_RAW, 32'h0000_07C0);
        axiWrite(`UILMS_OFF_MASK, 32'h0000_0540);
        rdChk("rawIndep", `UILMS_OFF_RAW, 32'h0000_07C0);
        rdChk("masked", `UILMS_OFF_MASKED, 32'h0000_0540);
        chk("srcIrq", 32'h0000_0540, srcIrq);
        chk("irqOn", 32'h1, uartIrq);
        axiWrite(`UILMS_OFF_CLEAR, 32'h0000_03C0);
        rdChk("rawClr", `UILMS_OFF_RAW, 32'h0000_0400);
        axiWrite(`UILMS_OFF_CLEAR, 32'h0000_0000);
        rdChk("clrZero", `UILMS_OFF_RAW, 32'h0000_0400);
        axiWrite(`UILMS_OFF_CLEAR, 32'h0000_07FF);
        chk("irqOff", 32'h0, uartIrq);
        // Modem pins are synchronised inside, so give them several cycles.
        setReadyInN    <= 1'b0;
        carrierInN     <= 1'b0;
        clearToSendInN <= 1'b0;
        ringInN        <= 1'b0;
        repeat (8) @(posedge mclk);
        rdChk("modem", `UILMS_OFF_RAW, 32'h0000_000F);
        // Each code pair is tested with receive just below and transmit just above its trip point, then at it.
        for (int i = 0; i < 5; i++) begin
            axiWrite(`UILMS_OFF_THRESHOLD, {26'h000_0000, i[2:0], 3'(4 - i)});
            rdChk("thrSel", `UILMS_OFF_THRESHOLD, {26'h0, i[2:0], 3'(4 - i)});
            rxLvl <= TRIP[i] - 5'h01;
            txLvl <= TRIP[4 - i] + 5'h01;
            axiWrite(`UILMS_OFF_CLEAR, 32'h0000_07FF);
            rdChk("noCross", `UILMS_OFF_RAW, 32'h0000_0000);
            rxLvl <= TRIP[i];
            txLvl <= TRIP[4 - i];
            repeat (3) @(posedge mclk);
            rdChk("cross", `UILMS_OFF_RAW, 32'h0000_0030);
            axiWrite(`UILMS_OFF_CLEAR, 32'h0000_0030);
            rdChk("held", `UILMS_OFF_RAW, 32'h0000_0000);
        end
        axiRead(8'h20);
        chk("unmapResp", `UILMS_RESP_SLVERR, lastResp);
        chk("unmapData", 32'h0000_0000, rdVal);
        axiWrite(8'h20, 32'h0000_0000);
        chk("unmapWrResp", `UILMS_RESP_SLVERR, lastResp);
        rdChk("unmapWrRaw", `UILMS_OFF_RAW, 32'h0000_0000);
        complete_run();
    end

endmodule // uilms_top_tb
